// ### pkg/qaro_pkg.sv
// Shared constants, types and the identification table for the quad read link.
package qaro_pkg;
  localparam logic [7:0] QUAD_OPC     = 8'hEB;
  localparam logic [7:0] IDENT_OPC    = 8'h9F;
  localparam logic [3:0] XIP_NIBBLE   = 4'hA;
  localparam logic [3:0] CMD_BITS     = 4'h8;
  localparam logic [3:0] ADDR_NIBS    = 4'h8;
  localparam logic [3:0] DUMMY_CYC    = 4'h4;
  localparam logic [3:0] QUAD_BYTE_CYC = 4'h2;
  localparam logic [3:0] SER_BYTE_CYC = 4'h8;
  localparam logic [6:0] ID_LAST_IDX  = 7'h50;
  localparam logic [7:0] ID_EXT_LEN   = 8'h4D;
  localparam logic [7:0] ALL_ONES     = 8'hFF;
  localparam logic [3:0] LANE0_OE     = 4'h1;
  localparam logic [3:0] LANE1_OE     = 4'h2;
  localparam logic [3:0] ALL_LANES_OE = 4'hF;
  localparam int         SYS_CLK_HZ   = 50_000_000;
  localparam int         QUAD_MAX_HZ  = 80_000_000;
  localparam int         IDENT_MAX_HZ = 50_000_000;
  localparam int         LANE_SYNC_LAT = 4;

  typedef enum logic [2:0] {
    D_START  = 3'h0,
    D_CMD    = 3'h1,
    D_ADDR   = 3'h2,
    D_DUMMY  = 3'h3,
    D_QDATA  = 3'h4,
    D_IDATA  = 3'h5,
    D_IGNORE = 3'h6
  } qaro_dst_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_CMD   = 3'h1,
    H_ADDR  = 3'h2,
    H_DUMMY = 3'h3,
    H_DATA  = 3'h4,
    H_END   = 3'h5
  } qaro_hst_t;

  // Bytes past 26h other than the all-ones span are outside this block and read zero.
  function automatic logic [7:0] qaro_id_byte(input logic [6:0] idx,
                                              input logic [7:0] manuf,
                                              input logic [7:0] dev_hi,
                                              input logic [7:0] dev_lo);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      7'h00: b = manuf;
      7'h01: b = dev_hi;
      7'h02: b = dev_lo;
      7'h03: b = ID_EXT_LEN;
      7'h10: b = 8'h51;
      7'h11: b = 8'h52;
      7'h12: b = 8'h59;
      7'h13: b = 8'h02;
      7'h15: b = 8'h40;
      7'h1B: b = 8'h27;
      7'h1C: b = 8'h36;
      7'h1F: b = 8'h0B;
      7'h20: b = 8'h0B;
      7'h21: b = 8'h09;
      7'h22: b = 8'h10;
      7'h23: b = 8'h01;
      7'h24: b = 8'h01;
      7'h25: b = 8'h02;
      7'h26: b = 8'h01;
      default: begin
        if ((idx >= 7'h07 && idx <= 7'h0F) || (idx >= 7'h3D && idx <= 7'h3F)) begin
          b = ALL_ONES;
        end
      end
    endcase
    return b;
  endfunction
endpackage

// ### pkg/qaro_link_if.sv
// Link between host controller and flash end: select, serial clock, four lanes.
`timescale 1ns/10ps
interface qaro_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  // An undriven lane floats high, as the pull-ups on the board would hold it.
  assign lane = (dev_oe & dev_o) | (host_oe & host_o) | ~(dev_oe | host_oe);

  modport host (output cs_n, output sck, output host_o, output host_oe, input lane);
  modport dev  (input cs_n, input sck, input lane, output dev_o, output dev_oe);
endinterface

// ### hdl/qaro_dev.sv
// Flash end: quad address read with continuous mode and identification read.
// How it works
// - Quad read opcode arrives serially, one bit per rise.
// - Address then mode byte, four bits per rise.
// - Four dummy clocks precede quad read data.
// - Array data returns from given address, nibble-wise.
// - Address increments per byte and wraps to zero.
// - Mode upper nibble A keeps opcode-less continuous mode.
// - Other mode nibble leaves continuous mode next frame.
// - Short invalid frame also leaves continuous mode.
// - Host releases lanes before first data fall.
// - Select high ends quad read at once.
// - Host keeps quad read clock within 80 MHz.
// - Identification opcode arrives serially on lane zero.
// - Identification bytes leave on lane one, falling edges.
// - Host keeps identification clock within 50 MHz.
// - Identification stream repeats every 648 clocks.
// - Select high ends identification output at once.
// - Identification ignored while busy with program work.
// - Byte 3 gives extended length; 4-6 reserved.
// - Positions 07h-0Fh and 3Dh-3Fh read all-ones.
// - Positions 10h-12h read ASCII Q, R, Y.
// - Position 15h reads 40h; alternate set zero.
// - Positions 1Bh-26h return timing and voltage codes.
// - Quad read opcode accepted only with quad enable set.
`timescale 1ns/10ps
module qaro_dev #(
  parameter int         ADDR_W      = 24,
  parameter int         MEM_BYTES   = 2 ** ADDR_W,
  parameter logic [7:0] MANUF_CODE  = 8'h5A,
  parameter logic [7:0] DEV_CODE_HI = 8'hC3,
  parameter logic [7:0] DEV_CODE_LO = 8'h3C
) (
  qaro_link_if.dev                 link,
  input  wire logic                rst,
  input  wire logic                busy,
  input  wire logic                quad_en,
  input  wire logic [7:0]          mem_data,
  output logic      [ADDR_W-1:0]   mem_addr,
  output logic                     xip_active
);
  // The three identity parameters above hold arbitrary neutral values.

  if (ADDR_W < 1 || ADDR_W > 24 || MEM_BYTES < 2 || MEM_BYTES > 2 ** ADDR_W) begin : g_chk
    $error("qaro_dev: array size does not fit the address width");
  end

  qaro_pkg::qaro_dst_t st_q;
  logic [3:0]          cnt_q;
  logic [7:0]          cmd_q;
  logic [31:0]         sh_q;
  logic                nib_q;
  logic [6:0]          idx_q;
  logic [ADDR_W-1:0]   addr_q;
  logic                xip_q;
  logic [3:0]          out_q;
  logic [3:0]          oe_q;

  // Control levels come from the system clock domain and are resynchronised
  // here. The link clock only runs inside frames, so a change is seen a few
  // link edges late; software should settle them before selecting.
  logic [2:0]          sync1_q;
  logic [2:0]          sync2_q;
  logic [2:0]          sync3_q;
  logic [2:0]          lvl_q;

  always_ff @(posedge link.sck) begin
    sync1_q <= {rst, busy, quad_en};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    if (sync2_q == sync3_q) begin
      lvl_q <= sync3_q;
    end
  end

  wire       rst_s  = lvl_q[2];
  wire       busy_s = lvl_q[1];
  wire       qen_s  = lvl_q[0];

  wire [7:0]  cmd_w   = {cmd_q[6:0], link.lane[0]};
  wire [31:0] sh_w    = {sh_q[27:0], link.lane};
  wire        cmd_end = (cnt_q == qaro_pkg::CMD_BITS - 4'h1);
  wire        adr_end = (cnt_q == qaro_pkg::ADDR_NIBS - 4'h1);
  wire        dum_end = (cnt_q == qaro_pkg::DUMMY_CYC - 4'h1);
  wire        bit_end = (cnt_q == qaro_pkg::SER_BYTE_CYC - 4'h1);
  wire        is_quad = (cmd_w == qaro_pkg::QUAD_OPC) && qen_s;
  wire        is_id   = (cmd_w == qaro_pkg::IDENT_OPC) && !busy_s;
  wire        mode_keep = (sh_w[7:4] == qaro_pkg::XIP_NIBBLE);
  // The wrap point follows the array size, which may be below the address range.
  wire        addr_top = (addr_q == ADDR_W'(MEM_BYTES - 1));

  qaro_pkg::qaro_dst_t cmd_next;
  assign cmd_next = is_quad ? qaro_pkg::D_ADDR :
                    is_id   ? qaro_pkg::D_IDATA : qaro_pkg::D_IGNORE;

  // Select high clears the frame at once, whatever the link clock does.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      st_q  <= qaro_pkg::D_START;
      cnt_q <= 4'h0;
      cmd_q <= 8'h00;
      sh_q  <= 32'h0000_0000;
      nib_q <= 1'b0;
      idx_q <= 7'h00;
    end else begin
      case (st_q)
        qaro_pkg::D_START: begin
          cmd_q <= cmd_w;
          sh_q  <= sh_w;
          cnt_q <= 4'h1;
          // The mode flag is cleared on this same edge, so a flag that has not
          // yet been through reset counts as off and an opcode is expected.
          st_q  <= qaro_pkg::D_CMD;
          if (xip_q) begin
            st_q <= qaro_pkg::D_ADDR;
          end
        end
        qaro_pkg::D_CMD: begin
          cmd_q <= cmd_w;
          cnt_q <= cmd_end ? 4'h0 : cnt_q + 4'h1;
          if (cmd_end) begin
            st_q <= cmd_next;
          end
        end
        qaro_pkg::D_ADDR: begin
          sh_q  <= sh_w;
          cnt_q <= adr_end ? 4'h0 : cnt_q + 4'h1;
          if (adr_end) begin
            st_q <= qaro_pkg::D_DUMMY;
          end
        end
        qaro_pkg::D_DUMMY: begin
          cnt_q <= dum_end ? 4'h0 : cnt_q + 4'h1;
          if (dum_end) begin
            st_q <= qaro_pkg::D_QDATA;
          end
        end
        qaro_pkg::D_QDATA: begin
          nib_q <= ~nib_q;
        end
        qaro_pkg::D_IDATA: begin
          cnt_q <= bit_end ? 4'h0 : cnt_q + 4'h1;
          if (bit_end) begin
            idx_q <= (idx_q == qaro_pkg::ID_LAST_IDX) ? 7'h00 : idx_q + 7'h01;
          end
        end
        qaro_pkg::D_IGNORE: begin
          cnt_q <= cnt_q;
        end
        default: begin
          st_q <= qaro_pkg::D_IGNORE;
        end
      endcase
    end
  end

  // The read address is loaded after the mode byte and steps after every
  // low nibble, so the array sees the next address a half clock ahead.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      addr_q <= '0;
    end else if (st_q == qaro_pkg::D_ADDR && adr_end) begin
      addr_q <= sh_w[ADDR_W+7:8];
    end else if (st_q == qaro_pkg::D_QDATA && nib_q) begin
      addr_q <= addr_top ? '0 : addr_q + 1'b1;
    end
  end

  // Every frame drops continuous mode on its first edge; only a complete
  // mode byte can restore it, so a short or broken frame leaves the mode.
  always_ff @(posedge link.sck) begin
    if (rst_s) begin
      xip_q <= 1'b0;
    end else if (st_q == qaro_pkg::D_START && !link.cs_n) begin
      xip_q <= 1'b0;
    end else if (st_q == qaro_pkg::D_ADDR && adr_end && !link.cs_n) begin
      xip_q <= mode_keep;
    end
  end

  wire [7:0] id_byte = qaro_pkg::qaro_id_byte(idx_q,
                                              MANUF_CODE,
                                              DEV_CODE_HI, DEV_CODE_LO);
  wire       id_bit  = id_byte[3'(~cnt_q[2:0])];
  wire [3:0] q_nib   = nib_q ? mem_data[3:0] : mem_data[7:4];

  wire [3:0] out_w = (st_q == qaro_pkg::D_QDATA) ? q_nib :
                     (st_q == qaro_pkg::D_IDATA) ? {2'b00, id_bit, 1'b0} : 4'h0;
  wire [3:0] oe_w  = (st_q == qaro_pkg::D_QDATA) ? qaro_pkg::ALL_LANES_OE :
                     (st_q == qaro_pkg::D_IDATA) ? qaro_pkg::LANE1_OE : 4'h0;

  // Lanes change on the falling edge so the host samples a settled value.
  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      out_q <= 4'h0;
      oe_q  <= 4'h0;
    end else begin
      out_q <= out_w;
      oe_q  <= oe_w;
    end
  end

  assign link.dev_o  = out_q;
  assign link.dev_oe = oe_q;
  assign mem_addr    = addr_q;
  assign xip_active  = xip_q;
endmodule

// ### hdl/qaro_host.sv
// Host controller end: makes select and serial clock, runs quad and identification reads.
`timescale 1ns/10ps
module qaro_host #(
  parameter int DIV_HALF = 5,
  parameter int LEN_W    = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             op_id,
  input  wire logic             cont,
  input  wire logic [23:0]      addr,
  input  wire logic [7:0]       mode,
  input  wire logic [LEN_W-1:0] len,
  output logic                  ready,
  output logic                  rd_valid,
  output logic [7:0]            rd_data,
  output logic                  done,
  qaro_link_if.host             link
);
  // Lane samples pass a four-stage synchroniser, so each half clock must
  // outlast that latency; this caps the link rate well below the limits.
  if (DIV_HALF < qaro_pkg::LANE_SYNC_LAT + 1 || DIV_HALF > 65535 || LEN_W < 1) begin : g_chk
    $error("qaro_host: divider or length width out of range");
  end
  if (qaro_pkg::SYS_CLK_HZ / (2 * DIV_HALF) > qaro_pkg::IDENT_MAX_HZ ||
      qaro_pkg::SYS_CLK_HZ / (2 * DIV_HALF) > qaro_pkg::QUAD_MAX_HZ) begin : g_rate
    $error("qaro_host: serial clock too fast");
  end

  qaro_pkg::qaro_hst_t st_q;
  logic [15:0]         dv_q;
  logic                sck_q;
  logic                cs_n_q;
  logic [3:0]          o_q;
  logic [3:0]          oe_q;
  logic [39:0]         tx_q;
  logic [3:0]          cnt_q;
  logic [LEN_W-1:0]    left_q;
  logic                quad_q;
  logic [7:0]          rx_q;
  logic [3:0]          ls1_q;
  logic [3:0]          ls2_q;
  logic [3:0]          ls3_q;
  logic [3:0]          lane_q;

  always_ff @(posedge clk_sys) begin
    ls1_q <= link.lane;
    ls2_q <= ls1_q;
    ls3_q <= ls2_q;
    if (ls2_q == ls3_q) begin
      lane_q <= ls3_q;
    end
  end

  wire       tick   = (dv_q == 16'(DIV_HALF - 1));
  wire       fall   = tick && sck_q;
  wire       run    = (st_q == qaro_pkg::H_CMD) || (st_q == qaro_pkg::H_ADDR) ||
                      (st_q == qaro_pkg::H_DUMMY) || (st_q == qaro_pkg::H_DATA);
  wire [7:0] rx_w   = quad_q ? {rx_q[3:0], lane_q} : {rx_q[6:0], lane_q[1]};
  wire       b_end  = quad_q ? (cnt_q == qaro_pkg::QUAD_BYTE_CYC - 4'h1) :
                               (cnt_q == qaro_pkg::SER_BYTE_CYC - 4'h1);
  wire [7:0] opc    = op_id ? qaro_pkg::IDENT_OPC : qaro_pkg::QUAD_OPC;
  wire       skip   = !op_id && cont;

  always_ff @(posedge clk_sys) begin
    if (rst || !(run || st_q == qaro_pkg::H_END)) begin
      dv_q  <= 16'h0000;
      sck_q <= 1'b0;
    end else begin
      dv_q  <= tick ? 16'h0000 : dv_q + 16'h0001;
      sck_q <= (tick && run) ? ~sck_q : sck_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q     <= qaro_pkg::H_IDLE;
      cs_n_q   <= 1'b1;
      o_q      <= 4'h0;
      oe_q     <= 4'h0;
      tx_q     <= 40'h00_0000_0000;
      cnt_q    <= 4'h0;
      left_q   <= '0;
      quad_q   <= 1'b0;
      rx_q     <= 8'h00;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      ready    <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      case (st_q)
        qaro_pkg::H_IDLE: begin
          ready <= 1'b1;
          if (start && ready) begin
            ready  <= 1'b0;
            cs_n_q <= 1'b0;
            quad_q <= !op_id;
            left_q <= len;
            cnt_q  <= 4'h0;
            if (skip) begin
              st_q <= qaro_pkg::H_ADDR;
              tx_q <= {addr, mode, 8'h00};
              o_q  <= addr[23:20];
              oe_q <= qaro_pkg::ALL_LANES_OE;
            end else begin
              st_q <= qaro_pkg::H_CMD;
              tx_q <= {opc, addr, mode};
              o_q  <= {3'b000, opc[7]};
              oe_q <= qaro_pkg::LANE0_OE;
            end
          end
        end
        qaro_pkg::H_CMD: if (fall) begin
          tx_q  <= tx_q << 1;
          o_q   <= {3'b000, tx_q[38]};
          cnt_q <= (cnt_q == qaro_pkg::CMD_BITS - 4'h1) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == qaro_pkg::CMD_BITS - 4'h1) begin
            st_q <= quad_q ? qaro_pkg::H_ADDR : qaro_pkg::H_DATA;
            o_q  <= quad_q ? tx_q[38:35] : 4'h0;
            oe_q <= quad_q ? qaro_pkg::ALL_LANES_OE : 4'h0;
          end
        end
        qaro_pkg::H_ADDR: if (fall) begin
          tx_q  <= tx_q << 4;
          o_q   <= tx_q[35:32];
          cnt_q <= (cnt_q == qaro_pkg::ADDR_NIBS - 4'h1) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == qaro_pkg::ADDR_NIBS - 4'h1) begin
            st_q <= qaro_pkg::H_DUMMY;
            o_q  <= 4'h0;
            oe_q <= 4'h0;
          end
        end
        qaro_pkg::H_DUMMY: if (fall) begin
          cnt_q <= (cnt_q == qaro_pkg::DUMMY_CYC - 4'h1) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == qaro_pkg::DUMMY_CYC - 4'h1) begin
            st_q <= qaro_pkg::H_DATA;
          end
        end
        qaro_pkg::H_DATA: if (fall) begin
          rx_q  <= rx_w;
          cnt_q <= b_end ? 4'h0 : cnt_q + 4'h1;
          if (b_end) begin
            rd_data  <= rx_w;
            rd_valid <= 1'b1;
            left_q   <= left_q - 1'b1;
            if (left_q <= 1) begin
              st_q   <= qaro_pkg::H_END;
              cs_n_q <= 1'b1;
            end
          end
        end
        qaro_pkg::H_END: if (tick) begin
          st_q <= qaro_pkg::H_IDLE;
          done <= 1'b1;
        end
        default: begin
          st_q <= qaro_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n    = cs_n_q;
  assign link.sck     = sck_q;
  assign link.host_o  = o_q;
  assign link.host_oe = oe_q;
endmodule

// ### verification/qaro_link_chk.sv
// Concurrent checks on the quad read link between the host and flash ends.
`timescale 1ns/10ps
module qaro_link_chk #(
  parameter int DIV_HALF = 5
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe
);
  logic [15:0] rise_q;
  logic        cont_q;
  int          hi_q;

  // Select high restarts the count at once, just as it clears the device's frame state.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rise_q <= 16'h0000;
      cont_q <= 1'b0;
    end else begin
      rise_q <= (rise_q == 16'hFFFF) ? rise_q : rise_q + 16'h0001;
      cont_q <= (rise_q == 16'h0000) ? (host_oe == 4'hF) : cont_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    hi_q <= (rst || !sck) ? 0 : hi_q + 1;
  end

  chk_lane_release: assert property (@(posedge clk_sys) disable iff (rst)
    (|dev_oe) |-> (host_oe == 4'h0)) else $error("both ends drive the lanes");
  chk_sel_ends_out: assert property (@(posedge clk_sys) disable iff (rst)
    cs_n |-> (dev_oe == 4'h0)) else $error("device drives while deselected");
  chk_dev_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
    (!cs_n && sck && $past(sck)) |-> ($stable(dev_o) && $stable(dev_oe)))
    else $error("device lanes moved while the clock was high");
  chk_host_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
    (!cs_n && sck && $past(sck)) |-> ($stable(host_o) && $stable(host_oe)))
    else $error("host lanes moved while the clock was high");
  chk_sck_high_len: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(sck) |-> (hi_q == DIV_HALF)) else $error("serial clock high time wrong");
  chk_oe_shape: assert property (@(posedge clk_sys) disable iff (rst)
    dev_oe inside {4'h0, 4'h2, 4'hF}) else $error("device lane enables malformed");
  chk_opc_lanes: assert property (@(posedge sck) disable iff (cs_n)
    (rise_q < 16'h0008) |-> (host_oe inside {4'h1, 4'hF})) else $error("frame head lanes wrong");
  chk_quad_wait: assert property (@(posedge sck) disable iff (cs_n)
    (dev_oe == 4'hF) |-> (rise_q >= (cont_q ? 16'h000C : 16'h0014)))
    else $error("quad data before the dummy clocks ended");
  chk_id_after_opc: assert property (@(posedge sck) disable iff (cs_n)
    (dev_oe == 4'h2) |-> (rise_q >= 16'h0008 && !cont_q)) else $error("id output too early");

  cov_quad_cont: cover property (@(posedge sck) disable iff (cs_n) dev_oe == 4'hF && cont_q);
  cov_quad_full: cover property (@(posedge sck) disable iff (cs_n) dev_oe == 4'hF && !cont_q);
  cov_id_out: cover property (@(posedge sck) disable iff (cs_n) dev_oe == 4'h2);
endmodule

// ### verification/testbench.sv
// Self-checking bench joining the host and flash ends over the quad read link.
`timescale 1ns/10ps
module testbench;
  // Identity codes are arbitrary values of this bench.
  localparam logic [7:0] MANUF  = 8'h5A;
  localparam logic [7:0] DEV_HI = 8'hC3;
  localparam logic [7:0] DEV_LO = 8'h3C;
  logic        clk_sys;
  logic        rst;
  logic        dev_rst;
  logic        start;
  logic        op_id;
  logic        cont;
  logic [23:0] addr;
  logic [7:0]  mode;
  logic [15:0] len;
  logic        ready;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  logic        busy;
  logic        quad_en;
  logic [7:0]  mem_data;
  logic [7:0]  mem_addr;
  logic        xip_active;
  logic        xip_e;
  logic [7:0]  m_r;
  int          n_mismatch;
  int          n_tests;

  qaro_link_if link ();
  qaro_host #(.DIV_HALF(5), .LEN_W(16)) i_qaro_host (.clk_sys(clk_sys), .rst(rst),
    .start(start), .op_id(op_id), .cont(cont), .addr(addr), .mode(mode), .len(len),
    .ready(ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .link(link));
  // A 256-byte array keeps the address wrap within reach of short reads.
  qaro_dev #(.ADDR_W(8), .MANUF_CODE(MANUF), .DEV_CODE_HI(DEV_HI), .DEV_CODE_LO(DEV_LO))
    i_qaro_dev (.link(link), .rst(dev_rst), .busy(busy), .quad_en(quad_en),
    .mem_data(mem_data), .mem_addr(mem_addr), .xip_active(xip_active));
  qaro_link_chk #(.DIV_HALF(5)) i_qaro_link_chk (.clk_sys(clk_sys), .rst(rst),
    .cs_n(link.cs_n), .sck(link.sck), .host_o(link.host_o), .host_oe(link.host_oe),
    .dev_o(link.dev_o), .dev_oe(link.dev_oe));

  always #10 clk_sys = ~clk_sys;

  function automatic logic [7:0] mem_f(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'h96;
  endfunction
  assign mem_data = mem_f(mem_addr);

  function automatic logic [7:0] id_f(input logic [6:0] i);
    case (i)
      7'h00: return MANUF;
      7'h01: return DEV_HI;
      7'h02: return DEV_LO;
      7'h03: return 8'h4D;
      7'h10: return 8'h51;
      7'h11: return 8'h52;
      7'h12: return 8'h59;
      7'h13, 7'h25: return 8'h02;
      7'h15: return 8'h40;
      7'h1B: return 8'h27;
      7'h1C: return 8'h36;
      7'h1F, 7'h20: return 8'h0B;
      7'h21: return 8'h09;
      7'h22: return 8'h10;
      7'h23, 7'h24, 7'h26: return 8'h01;
      default: return ((i >= 7'h07 && i <= 7'h0F) || (i >= 7'h3D && i <= 7'h3F)) ? 8'hFF : 8'h00;
    endcase
  endfunction

  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic hang(input int w, input int lim);
    if (w > lim) begin
      n_mismatch++;
      $display("ERROR wait limit expected done seen none");
      wrap_up();
    end
  endtask

  // Kind 0 leaves data and count unchecked, 1 expects the documented data, 2 expects floating lanes.
  task automatic xfer(input logic id, input logic c, input logic [23:0] a, input logic [7:0] m,
                      input int n, input int kind);
    int k;
    int w;
    logic [7:0] e;
    k = 0;
    w = 0;
    while (ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      w++;
      hang(w, 100);
    end
    @(posedge clk_sys);
    start <= 1'b1;
    op_id <= id;
    cont <= c;
    addr <= a;
    mode <= m;
    len <= 16'(n);
    @(posedge clk_sys);
    start <= 1'b0;
    w = 0;
    while (done !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      w++;
      hang(w, 20000);
      if (rd_valid === 1'b1) begin
        e = (kind == 2) ? 8'hFF : (id ? id_f(7'(k % 81)) : mem_f(a[7:0] + 8'(k)));
        if (kind != 0) check("rd_data", e, rd_data);
        k++;
      end
    end
    if (kind != 0) check("byte_count", 8'(n), 8'(k));
    check("cs_n", 8'h01, {7'h00, link.cs_n});
    check("dev_oe", 8'h00, {4'h0, link.dev_oe});
  endtask

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    dev_rst = 1'b1;
    start = 1'b0;
    op_id = 1'b0;
    cont = 1'b0;
    addr = 24'h000000;
    mode = 8'h00;
    len = 16'h0001;
    busy = 1'b0;
    quad_en = 1'b1;
    xip_e = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(32'h4F985A71));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    // The flash end only sees its reset through link clock edges, so warm-up frames come first.
    xfer(1'b1, 1'b0, 24'h000000, 8'h00, 2, 0);
    @(posedge clk_sys);
    dev_rst <= 1'b0;
    xfer(1'b1, 1'b0, 24'h000000, 8'h00, 1, 0);
    xfer(1'b1, 1'b0, 24'h000000, 8'h00, 84, 1);
    xfer(1'b0, 1'b0, 24'h3A5CFE, 8'h00, 4, 1);
    xfer(1'b0, 1'b0, 24'h000011, 8'hA3, 2, 1);
    check("xip_active", 8'h01, {7'h00, xip_active});
    xfer(1'b0, 1'b1, 24'h0000F0, 8'h5A, 3, 1);
    check("xip_active", 8'h00, {7'h00, xip_active});
    xfer(1'b0, 1'b0, 24'h000033, 8'h00, 2, 1);
    for (int i = 0; i < 16; i++) begin
      if (!xip_e && $urandom_range(3) == 0) begin
        xfer(1'b1, 1'b0, 24'h000000, 8'h00, $urandom_range(5, 1), 1);
      end else begin
        m_r = ($urandom_range(1) == 1) ? {4'hA, 4'($urandom)} : 8'($urandom);
        xfer(1'b0, xip_e, 24'($urandom), m_r, $urandom_range(6, 1), 1);
        xip_e = (m_r[7:4] == 4'hA);
      end
      check("xip_active", {7'h00, xip_e}, {7'h00, xip_active});
    end
    xfer(1'b0, xip_e, 24'h000020, 8'h00, 2, 1);
    @(posedge clk_sys);
    busy <= 1'b1;
    xfer(1'b0, 1'b0, 24'h000020, 8'h00, 2, 1);
    xfer(1'b1, 1'b0, 24'h000000, 8'h00, 3, 2);
    @(posedge clk_sys);
    busy <= 1'b0;
    quad_en <= 1'b0;
    xfer(1'b1, 1'b0, 24'h000000, 8'h00, 2, 1);
    xfer(1'b0, 1'b0, 24'h000040, 8'h00, 2, 2);
    wrap_up();
  end
endmodule
